// >>> shared/ras_pkg.sv
// constants and types for the return address stack
package ras_pkg;

  // stack geometry
  localparam int         PC_W      = 21;
  localparam int         PTR_W     = 5;
  localparam int         DEPTH     = 31;
  localparam logic [4:0] PTR_EMPTY = 5'h00;
  localparam logic [4:0] PTR_TOP   = 5'h1f;
  localparam logic [4:0] PTR_STEP  = 5'h01;

  // program space vectors and size
  localparam logic [20:0] RESET_VECTOR    = 21'h000000;
  localparam logic [20:0] HI_VECTOR       = 21'h000008;
  localparam logic [20:0] LO_VECTOR       = 21'h000018;
  localparam logic [20:0] UNDER_PC        = 21'h000000;
  localparam logic [20:0] PROG_IMPL_BYTES = 21'h008000;
  localparam logic [15:0] FETCH_BLANK     = 16'h0000;

  // register map, byte addresses
  localparam int         ADDR_W        = 8;
  localparam logic [7:0] STATUS_OFFSET = 8'h00;
  localparam logic [7:0] TOP_OFFSET    = 8'h04;

  // field positions
  localparam int FULL_BIT      = 7;
  localparam int UNDER_BIT     = 6;
  localparam int PTR_LSB       = 0;
  localparam int TOP_LOW_LSB   = 0;
  localparam int TOP_HIGH_LSB  = 8;
  localparam int TOP_UPPER_LSB = 16;
  localparam int TOP_UPPER_W   = 5;

  // values after reset
  localparam logic       FLAG_RESET   = 1'b0;
  localparam logic [7:0] SHADOW_RESET = 8'h00;

  // bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // stack operations requested by the sequencer
  typedef enum logic [2:0] {
    OP_NONE   = 3'b000,
    OP_CALL   = 3'b001,
    OP_RETURN = 3'b010,
    OP_INT_HI = 3'b011,
    OP_INT_LO = 3'b100,
    OP_PUSH   = 3'b101,
    OP_POP    = 3'b110
  } op_t;

endpackage

// >>> hw/return_address_stack.sv
// return address stack with fast register shadow and axi4-lite access
`timescale 1ns/1ps

// Overview of operation
// R1: fetches beyond implemented program memory return all zeros.
// R2: reset loads pc with 0000h; interrupts vector to 0008h or 0018h.
// R3: calls and interrupt acknowledges push; all return kinds pop.
// R4: call and return leave the pc latch registers untouched.
// R5: storage is 31 by 21 bits, 5-bit pointer, cleared by every reset; here reset empties only the pointer, entries keep their data.
// R6: pointer zero has no entry; entries live at one to thirty-one.
// R7: push increments pointer first, then writes pc to the new entry.
// R8: pop moves the current entry to pc, then decrements the pointer.
// R9: top entry bytes show the current entry; writes update it.
// R10: pointer ranges 0 to 31, readable and writable by software.
// R11: full flag sets on the thirty-first push without a pop.
// R12: option set: 31st push stores, sets full, resets device, pointer 0.
// R13: option clear: pointer stays 31; later pushes are discarded.
// R14: pop at pointer zero gives pc zero, sets underflow, pointer stays.
// R15: underflow resets the device only when the option is set.
// R16: both flags survive all resets but power-on; software clears them.
// R17: status has full bit 7, underflow bit 6, zero bit 5, pointer 4-0.
// R18: explicit push stores pc in a new top without changing flow.
// R19: explicit pop only decrements, leaving pc alone.
// R20: interrupt vectoring captures status, working and bank registers.
// R21: a fast return restores the shadow while popping.
// R22: a fast call captures the shadow while pushing.
// R23: option is static; device reset request is a one-cycle pulse.
module return_address_stack (
  input  wire logic                     aclk,
  input  wire logic                     aresetn,
  input  wire logic                     por_resetn,
  input  wire logic                     stack_reset_option,
  input  wire ras_pkg::op_t             op,
  input  wire logic                     op_fast,
  input  wire logic [20:0]              pc_in,
  input  wire logic [7:0]               status_in,
  input  wire logic [7:0]               working_register_in,
  input  wire logic [7:0]               bsr_in,
  output logic                          pc_load,
  output logic [20:0]                   pc_out,
  output logic                          restore_load,
  output logic [7:0]                    status_out,
  output logic [7:0]                    working_register_out,
  output logic [7:0]                    bsr_out,
  output logic                          stack_reset_req,
  input  wire logic                     fetch_req,
  input  wire logic [20:0]              fetch_addr,
  input  wire logic [15:0]              mem_rdata,
  output logic                          fetch_valid,
  output logic [15:0]                   fetch_data,
  input  wire logic                     awvalid,
  output logic                          awready,
  input  wire logic [ras_pkg::ADDR_W-1:0] awaddr,
  input  wire logic                     wvalid,
  output logic                          wready,
  input  wire logic [31:0]              wdata,
  input  wire logic [3:0]               wstrb,
  output logic                          bvalid,
  input  wire logic                     bready,
  output logic [1:0]                    bresp,
  input  wire logic                     arvalid,
  output logic                          arready,
  input  wire logic [ras_pkg::ADDR_W-1:0] araddr,
  output logic                          rvalid,
  input  wire logic                     rready,
  output logic [31:0]                   rdata,
  output logic [1:0]                    rresp
);

  // storage and pointer state
  logic [20:0] stack_mem [1:ras_pkg::DEPTH];
  logic [4:0]  pointer_value;
  logic        full_flag;
  logic        underflow_flag;
  // one-deep shadow of status, working and bank registers
  logic [7:0]  shadow_status;
  logic [7:0]  shadow_working_register;
  logic [7:0]  shadow_bsr;
  // write channel holding registers
  logic                        aw_have;
  logic                        w_have;
  logic [ras_pkg::ADDR_W-1:0]  awaddr_q;
  logic [31:0]                 wdata_q;
  logic [3:0]                  wstrb_q;
  // decoded operation terms
  logic        is_push;
  logic        is_pop;
  logic [4:0]  ptr_inc;
  logic [4:0]  ptr_dec;
  logic        push_ok;
  logic        push_fill;
  logic        pop_under;
  logic        pop_ok;
  logic        overflow_trip;
  logic        under_trip;
  logic        shadow_take;
  // software access terms
  logic        wr_go;
  logic        sw_status_write;
  logic        sw_top_write;
  logic        clear_full;
  logic        clear_under;
  logic [20:0] top_merged;
  logic [20:0] lane_mask;

  // entry behind a pointer; zero has nothing behind it
  function automatic logic [20:0] top_read(
    input logic [4:0] ptr
  );
    // R6: no entry at zero
    return (ptr == ras_pkg::PTR_EMPTY) ? ras_pkg::UNDER_PC : stack_mem[ptr];
  endfunction

  // whole register word seen by a bus read
  function automatic logic [31:0] reg_read(
    input logic [ras_pkg::ADDR_W-1:0] addr
  );
    logic [31:0] word;
    word = 32'h00000000;
    if (addr == ras_pkg::TOP_OFFSET) begin
      word[20:0] = top_read(pointer_value);
    end else if (addr == ras_pkg::STATUS_OFFSET) begin
      // R17: flags high, bit 5 zero
      word[ras_pkg::FULL_BIT]           = full_flag;
      word[ras_pkg::UNDER_BIT]          = underflow_flag;
      word[ras_pkg::PTR_LSB +: 5]       = pointer_value;
    end
    return word;
  endfunction

  // addresses that answer okay on the bus
  function automatic logic addr_mapped(
    input logic [ras_pkg::ADDR_W-1:0] addr
  );
    return (addr == ras_pkg::STATUS_OFFSET) || (addr == ras_pkg::TOP_OFFSET);
  endfunction

  // classify the sequencer request
  // R3: calls and interrupts push
  assign is_push = (op == ras_pkg::OP_CALL)   ||
                   (op == ras_pkg::OP_INT_HI) ||
                   (op == ras_pkg::OP_INT_LO) ||
                   (op == ras_pkg::OP_PUSH);
  // R3: every return kind pops
  assign is_pop  = (op == ras_pkg::OP_RETURN) ||
                   (op == ras_pkg::OP_POP);
  assign ptr_inc = pointer_value + ras_pkg::PTR_STEP;
  assign ptr_dec = pointer_value - ras_pkg::PTR_STEP;
  // R13: at 31 a push is dropped
  assign push_ok   = is_push && (pointer_value != ras_pkg::PTR_TOP);
  // R11: this push fills the stack
  assign push_fill = push_ok && (ptr_inc == ras_pkg::PTR_TOP);
  // R14: pop with nothing stacked
  assign pop_under = is_pop && (pointer_value == ras_pkg::PTR_EMPTY);
  assign pop_ok    = is_pop && !pop_under;
  // R15: reset only with option
  assign overflow_trip = push_fill && stack_reset_option;
  assign under_trip    = pop_under && stack_reset_option;
  // R20: interrupt entry captures
  assign shadow_take = (op == ras_pkg::OP_INT_HI) ||
                       (op == ras_pkg::OP_INT_LO) ||
                       ((op == ras_pkg::OP_CALL) && op_fast);
  // a register write fires once address and data are both held
  assign wr_go = aw_have && w_have && !bvalid;
  assign sw_status_write = wr_go && wstrb_q[0] &&
                           (awaddr_q == ras_pkg::STATUS_OFFSET);
  // top writes yield to a stack operation in the same cycle
  assign sw_top_write    = wr_go && (op == ras_pkg::OP_NONE) &&
                           (awaddr_q == ras_pkg::TOP_OFFSET) &&
                           (pointer_value != ras_pkg::PTR_EMPTY);
  // flags only clear when a zero is written to them
  assign clear_full  = sw_status_write && !wdata_q[ras_pkg::FULL_BIT];
  assign clear_under = sw_status_write && !wdata_q[ras_pkg::UNDER_BIT];

  // byte lanes merged into the current entry; one strobe per lane
  assign lane_mask = {{ras_pkg::TOP_UPPER_W{wstrb_q[2]}},
                      {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  always_comb begin
    top_merged = (top_read(pointer_value) & ~lane_mask) |
                 (wdata_q[20:0] & lane_mask);
  end

  // stack pointer
  always_ff @(posedge aclk) begin
    // R5: any reset empties it
    if (!aresetn || !por_resetn) begin
      pointer_value <= ras_pkg::PTR_EMPTY;
    // R12: full push with option
    end else if (overflow_trip) begin
      pointer_value <= ras_pkg::PTR_EMPTY;
    // R7: increment before write
    end else if (push_ok) begin
      pointer_value <= ptr_inc;
    // R19: pop just decrements
    end else if (pop_ok) begin
      pointer_value <= ptr_dec;
    // R10: software sets pointer; a stack op wins
    end else if (sw_status_write && !is_push && !is_pop) begin
      pointer_value <= wdata_q[ras_pkg::PTR_LSB +: 5];
    end
  end

  // entry storage; data only, so it carries no reset
  always_ff @(posedge aclk) begin
    // R7: write at new pointer
    if (push_ok) begin
      stack_mem[ptr_inc] <= pc_in;
    // R9: software edits top
    end else if (sw_top_write) begin
      stack_mem[pointer_value] <= top_merged;
    end
  end

  // full flag, kept across every reset but power-on
  always_ff @(posedge aclk) begin
    // R16: only power-on clears
    if (!por_resetn) begin
      full_flag <= ras_pkg::FLAG_RESET;
    // R11: set beats a clear
    end else if (push_fill) begin
      full_flag <= 1'b1;
    end else if (clear_full) begin
      full_flag <= 1'b0;
    end
  end

  // underflow flag, same lifetime as the full flag
  always_ff @(posedge aclk) begin
    // R16: only power-on clears
    if (!por_resetn) begin
      underflow_flag <= ras_pkg::FLAG_RESET;
    // R14: set beats a clear
    end else if (pop_under) begin
      underflow_flag <= 1'b1;
    end else if (clear_under) begin
      underflow_flag <= 1'b0;
    end
  end

  // program counter load toward the sequencer
  // latches are not ours: only pc itself is ever driven here
  // R4: latches left alone
  always_ff @(posedge aclk) begin
    // R2: reset vector
    if (!aresetn) begin
      pc_load <= 1'b1;
      pc_out  <= ras_pkg::RESET_VECTOR;
    end else begin
      // R18: push keeps flow
      pc_load <= 1'b0;
      unique case (op)
        // R8: entry out before decrement
        ras_pkg::OP_RETURN: begin
          pc_load <= 1'b1;
          // R14: underflow returns zero
          pc_out  <= top_read(pointer_value);
        end
        // R2: fixed interrupt vectors
        ras_pkg::OP_INT_HI: begin
          pc_load <= 1'b1;
          pc_out  <= ras_pkg::HI_VECTOR;
        end
        ras_pkg::OP_INT_LO: begin
          pc_load <= 1'b1;
          pc_out  <= ras_pkg::LO_VECTOR;
        end
        default: pc_load <= 1'b0;
      endcase
    end
  end

  // shadow capture; a later capture simply overwrites
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shadow_status <= ras_pkg::SHADOW_RESET;
      shadow_working_register   <= ras_pkg::SHADOW_RESET;
      shadow_bsr    <= ras_pkg::SHADOW_RESET;
    // R22: fast call or interrupt
    end else if (shadow_take) begin
      shadow_status <= status_in;
      shadow_working_register   <= working_register_in;
      shadow_bsr    <= bsr_in;
    end
  end

  // shadow restore on a fast return
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      restore_load <= 1'b0;
      status_out   <= ras_pkg::SHADOW_RESET;
      working_register_out     <= ras_pkg::SHADOW_RESET;
      bsr_out      <= ras_pkg::SHADOW_RESET;
    end else begin
      // R21: restore with the pop
      restore_load <= (op == ras_pkg::OP_RETURN) && op_fast;
      status_out   <= shadow_status;
      working_register_out     <= shadow_working_register;
      bsr_out      <= shadow_bsr;
    end
  end

  // device reset request; the reset itself clears this too
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stack_reset_req <= 1'b0;
    end else begin
      // R23: one-cycle request
      stack_reset_req <= overflow_trip || under_trip;
    end
  end

  // instruction fetch filter, one cycle behind the request
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fetch_valid <= 1'b0;
      fetch_data  <= ras_pkg::FETCH_BLANK;
    end else begin
      fetch_valid <= fetch_req;
      // R1: unimplemented reads zero
      if (fetch_addr < ras_pkg::PROG_IMPL_BYTES) begin
        fetch_data <= mem_rdata;
      end else begin
        fetch_data <= ras_pkg::FETCH_BLANK;
      end
    end
  end

  // write address channel; ready drops until the response is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready  <= 1'b1;
      aw_have  <= 1'b0;
      awaddr_q <= '0;
    end else if (awvalid && awready) begin
      awready  <= 1'b0;
      aw_have  <= 1'b1;
      awaddr_q <= awaddr;
    end else if (wr_go) begin
      aw_have <= 1'b0;
    end else if (bvalid && bready) begin
      awready <= 1'b1;
    end
  end

  // write data channel, taken in either order against the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready  <= 1'b1;
      w_have  <= 1'b0;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
    end else if (wvalid && wready) begin
      wready  <= 1'b0;
      w_have  <= 1'b1;
      wdata_q <= wdata;
      wstrb_q <= wstrb;
    end else if (wr_go) begin
      w_have <= 1'b0;
    end else if (bvalid && bready) begin
      wready <= 1'b1;
    end
  end

  // write response; unmapped addresses answer decode error
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= ras_pkg::RESP_OKAY;
    end else if (wr_go) begin
      bvalid <= 1'b1;
      bresp  <= addr_mapped(awaddr_q) ? ras_pkg::RESP_OKAY :
                                        ras_pkg::RESP_DECERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // read channel; data sampled at the address handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h00000000;
      rresp   <= ras_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      // R17: status layout on read; unmapped reads zero
      rdata   <= reg_read(araddr);
      rresp   <= addr_mapped(araddr) ? ras_pkg::RESP_OKAY :
                                       ras_pkg::RESP_DECERR;
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end

endmodule

// >>> testbench/ras_checker_asserts.sv
// port-level checks on the return address stack
`timescale 1ns/1ps
module ras_checker (
  input wire logic          aclk,
  input wire logic          aresetn,
  input wire logic          stack_reset_option,
  input wire ras_pkg::op_t  op,
  input wire logic          op_fast,
  input wire logic          pc_load,
  input wire logic [20:0]   pc_out,
  input wire logic          restore_load,
  input wire logic          stack_reset_req,
  input wire logic          fetch_req,
  input wire logic [20:0]   fetch_addr,
  input wire logic [15:0]   mem_rdata,
  input wire logic          fetch_valid,
  input wire logic [15:0]   fetch_data
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_FETCH_ZERO: assert property (
    fetch_req && fetch_addr >= 21'h008000 |=> fetch_valid && !fetch_data)
    else $error("fetch past memory not zero");
  AST_FETCH_PASS: assert property (
    fetch_req && fetch_addr < 21'h008000
    |=> fetch_valid && fetch_data == $past(mem_rdata))
    else $error("fetch data lost");
  AST_INT_HI: assert property (
    op == ras_pkg::OP_INT_HI |=> pc_load && pc_out == 21'h000008)
    else $error("high vector wrong");
  AST_INT_LO: assert property (
    op == ras_pkg::OP_INT_LO |=> pc_load && pc_out == 21'h000018)
    else $error("low vector wrong");
  // reset vector, checked through the reset itself
  AST_RESET_PC: assert property (disable iff (1'b0)
    !aresetn |=> pc_load && pc_out == 21'h000000)
    else $error("reset vector wrong");
  AST_RESTORE: assert property (
    restore_load == $past(op == ras_pkg::OP_RETURN && op_fast))
    else $error("restore pulse wrong");
  AST_NO_LOAD: assert property (
    op inside {ras_pkg::OP_CALL, ras_pkg::OP_PUSH, ras_pkg::OP_POP}
    |=> !pc_load)
    else $error("push or pop loaded pc");
  // request only with option and a stack op
  AST_REQ_OPT: assert property (
    stack_reset_req |-> stack_reset_option && $past(op) != ras_pkg::OP_NONE)
    else $error("reset request without cause");
endmodule

bind return_address_stack ras_checker ras_checker_i (
  .aclk(aclk), .aresetn(aresetn), .stack_reset_option(stack_reset_option),
  .op(op), .op_fast(op_fast), .pc_load(pc_load), .pc_out(pc_out),
  .restore_load(restore_load), .stack_reset_req(stack_reset_req),
  .fetch_req(fetch_req), .fetch_addr(fetch_addr), .mem_rdata(mem_rdata),
  .fetch_valid(fetch_valid), .fetch_data(fetch_data));

// >>> testbench/seq_model.sv
// sequencer and program memory model driving the stack
`timescale 1ns/1ps
module seq_model (
  input  wire logic        aclk,
  input  wire logic        pc_load,
  input  wire logic [20:0] pc_out,
  input  wire logic        restore_load,
  input  wire logic [7:0]  status_out,
  input  wire logic [7:0]  working_register_out,
  input  wire logic [7:0]  bsr_out,
  input  wire logic        fetch_valid,
  input  wire logic [15:0] fetch_data,
  output ras_pkg::op_t     op,
  output logic             op_fast,
  output logic [20:0]      pc_in,
  output logic [7:0]       status_in,
  output logic [7:0]       working_register_in,
  output logic [7:0]       bsr_in,
  output logic             fetch_req,
  output logic [20:0]      fetch_addr,
  output logic [15:0]      mem_rdata
);
  logic [21:0] got_pc;
  logic [24:0] got_sh;
  logic [16:0] got_fd;
  // memory word is a pattern of its address, present same cycle
  assign mem_rdata = fetch_addr[15:0] ^ 16'h5a5a;
  initial begin
    op = ras_pkg::OP_NONE;
    {op_fast, pc_in, status_in, working_register_in, bsr_in} = '0;
    {fetch_req, fetch_addr} = '0;
  end
  // one-cycle op; pulses stand until the next edge, read there
  task automatic issue(input ras_pkg::op_t o, input logic f,
                       input logic [20:0] pc, input logic [7:0] s);
    op <= o;
    op_fast <= f;
    pc_in <= pc;
    status_in <= s;
    working_register_in <= ~s;
    bsr_in <= s + 8'h01;
    @(posedge aclk);
    op <= ras_pkg::OP_NONE;
    op_fast <= 1'b0;
    pc_in <= ~pc; // stale value never lingers
    @(posedge aclk);
    got_pc = {pc_load, pc_out};
    got_sh = {restore_load, status_out, working_register_out, bsr_out};
  endtask
  // single fetch, answer one cycle later
  task automatic fetch(input logic [20:0] a);
    fetch_req <= 1'b1;
    fetch_addr <= a;
    @(posedge aclk);
    fetch_req <= 1'b0;
    @(posedge aclk);
    got_fd = {fetch_valid, fetch_data};
  endtask
endmodule

// >>> testbench/tb.sv
// self-checking bench for the return address stack
`timescale 1ns/1ps
module tb;
  logic        aclk, aresetn, por_resetn, opt, pc_load, restore_load;
  logic        stack_reset_req, op_fast, fetch_req, fetch_valid;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [20:0] pc_in, pc_out, fetch_addr;
  logic [7:0]  status_in, working_register_in, bsr_in, status_out, working_register_out, bsr_out;
  logic [7:0]  awaddr, araddr;
  logic [15:0] mem_rdata, fetch_data;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, r;
  ras_pkg::op_t op;
  int          err_count, tests_run, cycles, req_seen;

  return_address_stack return_address_stack_i (.aclk(aclk),
    .aresetn(aresetn), .por_resetn(por_resetn), .stack_reset_option(opt),
    .op(op), .op_fast(op_fast), .pc_in(pc_in), .status_in(status_in),
    .working_register_in(working_register_in), .bsr_in(bsr_in), .pc_load(pc_load), .pc_out(pc_out),
    .restore_load(restore_load), .status_out(status_out),
    .working_register_out(working_register_out), .bsr_out(bsr_out),
    .stack_reset_req(stack_reset_req), .fetch_req(fetch_req),
    .fetch_addr(fetch_addr), .mem_rdata(mem_rdata),
    .fetch_valid(fetch_valid), .fetch_data(fetch_data), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
    .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp));
  seq_model seq_model_i (.aclk(aclk), .pc_load(pc_load), .pc_out(pc_out),
    .restore_load(restore_load), .status_out(status_out),
    .working_register_out(working_register_out), .bsr_out(bsr_out), .fetch_valid(fetch_valid),
    .fetch_data(fetch_data), .op(op), .op_fast(op_fast), .pc_in(pc_in),
    .status_in(status_in), .working_register_in(working_register_in), .bsr_in(bsr_in),
    .fetch_req(fetch_req), .fetch_addr(fetch_addr), .mem_rdata(mem_rdata));

  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  // watchdog, plus a tally of reset requests
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (stack_reset_req === 1'b1) req_seen <= req_seen + 1;
    if (cycles == 5000) begin
      err_count++;
      final_report();
    end
  end
  task automatic final_report();
    $display("checks %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // axi4-lite write; address and data offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid && bready));
    r = bresp;
    bready <= 1'b0;
  endtask
  // axi4-lite read with data and response compare
  task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                    input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid && rready));
    chk(rdata, ed);
    chk(rresp, er);
    rready <= 1'b0;
  endtask
  // hold one or both resets, flags survive the plain one
  task automatic rst(input logic por);
    aresetn <= 1'b0;
    por_resetn <= ~por;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    por_resetn <= 1'b1;
    @(posedge aclk);
  endtask
  // 31 calls from an empty stack, pc values 2..62
  task automatic fill(input logic o);
    opt <= o;
    for (int i = 1; i <= 31; i++)
      seq_model_i.issue(ras_pkg::OP_CALL, 1'b0, 21'(2 * i), 8'h00);
  endtask

  initial begin
    {aresetn, por_resetn, opt, awvalid, wvalid, bready} = '0;
    {arvalid, rready, awaddr, araddr, wdata} = '0;
    {err_count, tests_run, cycles, req_seen} = '0;
    wstrb = 4'hf;
    rst(1'b1);
    rd(8'h00, 32'h0, 2'h0);
    seq_model_i.issue(ras_pkg::OP_CALL, 1'b0, 21'h000100, 8'h00);
    seq_model_i.issue(ras_pkg::OP_CALL, 1'b0, 21'h000200, 8'h00);
    seq_model_i.issue(ras_pkg::OP_PUSH, 1'b0, 21'h000300, 8'h00);
    rd(8'h00, 32'h03, 2'h0);
    rd(8'h04, 32'h000300, 2'h0);
    seq_model_i.issue(ras_pkg::OP_POP, 1'b0, 21'h0, 8'h00);
    chk(seq_model_i.got_pc[21], 1'b0);
    rd(8'h04, 32'h000200, 2'h0);
    wr(8'h04, 32'h001abc);
    seq_model_i.issue(ras_pkg::OP_RETURN, 1'b0, 21'h0, 8'h00);
    chk(seq_model_i.got_pc, {1'b1, 21'h001abc});
    seq_model_i.issue(ras_pkg::OP_INT_LO, 1'b0, 21'h000400, 8'h34);
    chk(seq_model_i.got_pc, {1'b1, 21'h000018});
    seq_model_i.issue(ras_pkg::OP_INT_HI, 1'b0, 21'h000402, 8'h56);
    chk(seq_model_i.got_pc, {1'b1, 21'h000008});
    seq_model_i.issue(ras_pkg::OP_RETURN, 1'b1, 21'h0, 8'h77);
    chk(seq_model_i.got_pc, {1'b1, 21'h000402});
    chk(seq_model_i.got_sh, 25'h156a957);
    seq_model_i.issue(ras_pkg::OP_CALL, 1'b1, 21'h000500, 8'h9a);
    seq_model_i.issue(ras_pkg::OP_RETURN, 1'b1, 21'h0, 8'h11);
    chk(seq_model_i.got_sh, 25'h19a659b);
    wr(8'h00, 32'h3f);
    rd(8'h00, 32'h1f, 2'h0);
    wr(8'h08, 32'h1);
    chk(r, 2'h3);
    rd(8'h08, 32'h0, 2'h3);
    // overflow with the option clear: extra push is dropped
    wr(8'h00, 32'h0);
    fill(1'b0);
    rd(8'h00, 32'h9f, 2'h0);
    seq_model_i.issue(ras_pkg::OP_CALL, 1'b0, 21'h01fffe, 8'h00);
    rd(8'h04, 32'h3e, 2'h0);
    rd(8'h00, 32'h9f, 2'h0);
    chk(req_seen, 0);
    // overflow with the option set: request and empty pointer
    wr(8'h00, 32'h0);
    fill(1'b1);
    rd(8'h00, 32'h80, 2'h0);
    chk(req_seen, 1);
    // a live entry so the plain reset must really empty the pointer
    seq_model_i.issue(ras_pkg::OP_CALL, 1'b0, 21'h000600, 8'h00);
    rst(1'b0);
    rd(8'h00, 32'h80, 2'h0);
    // underflow without and with the option
    wr(8'h00, 32'h0);
    opt <= 1'b0;
    seq_model_i.issue(ras_pkg::OP_RETURN, 1'b0, 21'h0, 8'h00);
    chk(seq_model_i.got_pc, {1'b1, 21'h0});
    rd(8'h00, 32'h40, 2'h0);
    chk(req_seen, 1);
    opt <= 1'b1;
    seq_model_i.issue(ras_pkg::OP_RETURN, 1'b0, 21'h0, 8'h00);
    rd(8'h00, 32'h40, 2'h0);
    chk(req_seen, 2);
    rst(1'b0);
    rd(8'h00, 32'h40, 2'h0);
    rst(1'b1);
    rd(8'h00, 32'h0, 2'h0);
    rd(8'h04, 32'h0, 2'h0);
    seq_model_i.fetch(21'h007ffe);
    chk(seq_model_i.got_fd, {1'b1, 16'h7ffe ^ 16'h5a5a});
    seq_model_i.fetch(21'h008000);
    chk(seq_model_i.got_fd, {1'b1, 16'h0000});
    final_report();
  end
endmodule
